// >>> verilog/smio_pkg.sv
// Shared constants, opcodes, state codes and helper functions of the multi-lane buffer transfer block.
package smio_pkg;

  // Widths of the cache buffer column and of the serial fields.
  localparam int COL_W      = 12;
  localparam int ADDR_BITS  = 16;
  localparam int BYTE_BITS  = 8;
  localparam int DUMMY_CLKS = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W     = BYTE_BITS + COL_W;

  // Opcodes recognised on the link.
  localparam logic [7:0] OP_RD_DUAL       = 8'h3b;
  localparam logic [7:0] OP_RD_QUAD       = 8'h6b;
  localparam logic [7:0] OP_LOAD          = 8'h02;
  localparam logic [7:0] OP_LOAD_RND      = 8'h84;
  localparam logic [7:0] OP_LOAD_QUAD     = 8'h32;
  localparam logic [7:0] OP_LOAD_QUAD_RND = 8'h34;
  localparam logic [7:0] OP_FAST_DUAL     = 8'hbb;
  localparam logic [7:0] OP_FAST_QUAD     = 8'heb;
  localparam logic [7:0] OP_RESET         = 8'hff;

  // Lane counts, held as the number of data lanes in use.
  localparam logic [2:0] LANE1 = 3'h1;
  localparam logic [2:0] LANE2 = 3'h2;
  localparam logic [2:0] LANE4 = 3'h4;

  // Counter values and the empty lane enable pattern.
  localparam logic [4:0] CNT_ZERO   = 5'h00;
  localparam logic [4:0] DUMMY_LAST = 5'(DUMMY_CLKS - 1);
  localparam logic [3:0] OE_NONE    = 4'h0;

  // Link sequencer states, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ADDR  = 6'h02,
    ST_DUMMY = 6'h04,
    ST_RDATA = 6'h08,
    ST_WDATA = 6'h10,
    ST_SKIP  = 6'h20
  } smio_state_t;

  // Index of the last clock of a field of the given bit count on the given lanes.
  function automatic logic [4:0] last_tick(input int bits, input logic [2:0] lanes);
    int clks;
    clks = bits;
    if (lanes == LANE4) begin
      clks = bits / 4;
    end else if (lanes == LANE2) begin
      clks = bits / 2;
    end
    return 5'(clks - 1);
  endfunction : last_tick

  // Output enable pattern for the given lanes.
  function automatic logic [3:0] lane_mask(input logic [2:0] lanes);
    logic [3:0] m;
    m = 4'h1;
    if (lanes == LANE4) begin
      m = 4'hf;
    end else if (lanes == LANE2) begin
      m = 4'h3;
    end
    return m;
  endfunction : lane_mask

  // Shifts the sampled lanes into the receive register, highest lane as most significant bit.
  function automatic logic [15:0] shift_in(input logic [15:0] sh, input logic [3:0] io, input logic [2:0] lanes);
    logic [15:0] r;
    r = {sh[14:0], io[0]};
    if (lanes == LANE4) begin
      r = {sh[11:0], io[3:0]};
    end else if (lanes == LANE2) begin
      r = {sh[13:0], io[1:0]};
    end
    return r;
  endfunction : shift_in

  // Next column, wrapping within the buffer.
  function automatic logic [COL_W-1:0] col_next(input logic [COL_W-1:0] col);
    return col + 12'h001;
  endfunction : col_next

endpackage : smio_pkg

// >>> verilog/smio_fifo_if.sv
// Interface joining the sequencer to the load data FIFO.
`timescale 1ns/1ps
interface smio_fifo_if #(
  parameter int W = 20
);
  logic         wr_valid;  // Producer offers a word.
  logic         wr_ready;  // FIFO has room.
  logic [W-1:0] wr_data;   // Word offered.
  logic         rd_valid;  // FIFO holds a word at its output.
  logic         rd_ready;  // Consumer takes the word.
  logic [W-1:0] rd_data;   // Word at the output.

  // Side that fills and drains the FIFO.
  modport fill (output wr_valid, output wr_data, input wr_ready,
                input rd_valid, input rd_data, output rd_ready);
  // The FIFO itself.
  modport store (input wr_valid, input wr_data, output wr_ready,
                 output rd_valid, output rd_data, input rd_ready);
endinterface : smio_fifo_if

// >>> verilog/smio_fifo.sv
// Load data FIFO with a registered output word.
`timescale 1ns/1ps
module smio_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic   ref_clk,
  input wire logic   resetn,
  // FIFO ports.
  smio_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);

  // Whole FIFO state, including the storage array.
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } smio_fifo_state_t;

  smio_fifo_state_t s;       // Registered state.
  smio_fifo_state_t next_s;  // Next state.
  logic             push;    // A word enters this cycle.
  logic             pop;     // A word moves to the output register.

  // Room and output status come straight from the registered state.
  assign f.wr_ready = (s.cnt != (AW+1)'(DEPTH));
  assign f.rd_valid = s.ov;
  assign f.rd_data  = s.od;

  // Moves words in, and from storage into the output register when it is free.
  always_comb begin
    next_s = s;
    push   = f.wr_valid && (s.cnt != (AW+1)'(DEPTH));
    pop    = (s.cnt != '0) && (!s.ov || f.rd_ready);
    if (f.rd_ready) begin
      next_s.ov = 1'b0;
    end
    if (pop) begin
      next_s.od = s.mem[s.rp];
      next_s.ov = 1'b1;
      next_s.rp = s.rp + 1'b1;
    end
    if (push) begin
      next_s.mem[s.wp] = f.wr_data;
      next_s.wp        = s.wp + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (!resetn) begin
      next_s = '0;
    end
  end

  // Registers the state.
  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end
endmodule : smio_fifo

// >>> verilog/smio_xfer.sv
// Serial link sequencer for multi-lane cache buffer reads and program loads.
// Functional notes
// - Dual buffer read shifts two bits per clock.
// - Device drives lanes during dual read latency.
// - Quad buffer read drives no lanes during latency, shifts four bits.
// - Single-lane loads write serial data into buffer.
// - Quad loads capture four bits per clock.
// - Fast reads wait eight dummy clocks first.
// - Write-protect pin ignored during reads.
`timescale 1ns/1ps
module smio_xfer #(
  parameter int DEPTH = smio_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic                        ref_clk,
  input  wire logic                        resetn,
  // Link pins.
  input  wire logic                        sck,
  input  wire logic                        cs_n,
  input  wire logic [3:0]                  data_lanes_zero_to_three_in,
  output logic      [3:0]                  data_lanes_zero_to_three_out,
  output logic      [3:0]                  data_lanes_zero_to_three_oe,
  input  wire logic                        wp_n,
  // Cache buffer read port.
  output logic                             rd_req,
  output logic      [smio_pkg::COL_W-1:0]  rd_col,
  input  wire logic                        rd_ack,
  input  wire logic [7:0]                  rd_data,
  // Cache buffer write port.
  output logic                             wr_valid,
  input  wire logic                        wr_ready,
  output logic      [7:0]                  wr_data,
  output logic      [smio_pkg::COL_W-1:0]  wr_col,
  // Device control and status.
  output logic                             buf_fill,
  output logic                             soft_reset,
  output logic                             load_overrun,
  output logic                             wp_low_load
);

  // Whole sequencer state.
  typedef struct packed {
    logic                        sck_m;    // Clock synchroniser, first stage.
    logic                        sck_s;    // Clock synchroniser, second stage.
    logic                        sck_d;    // Delayed copy for edge finding.
    logic                        cs_m;     // Select synchroniser, first stage.
    logic                        cs_s;     // Select synchroniser, second stage.
    logic [3:0]                  io_m;     // Lane synchroniser, first stage.
    logic [3:0]                  io_s;     // Lane synchroniser, second stage.
    logic                        wp_m;     // Protect synchroniser, first stage.
    logic                        wp_s;     // Protect synchroniser, second stage.
    smio_pkg::smio_state_t       st;       // Sequencer state.
    logic [4:0]                  cnt;      // Link clocks within the current field.
    logic [2:0]                  lanes;    // Lanes used by the current field.
    logic [7:0]                  op;       // Latched opcode.
    logic [15:0]                 sh;       // Receive shift register.
    logic [smio_pkg::COL_W-1:0]  col;      // Current buffer column.
    logic [7:0]                  tx;       // Byte being shifted out.
    logic [7:0]                  nxt;      // Prefetched next read byte.
    logic                        nxt_ok;   // Prefetched byte is present.
    logic                        pend;     // Buffer read outstanding.
    logic                        rd_req;   // Buffer read request pulse.
    logic [smio_pkg::COL_W-1:0]  rd_col;   // Column of the request.
    logic [3:0]                  io_out;   // Lane output values.
    logic [3:0]                  io_oe;    // Lane output enables.
    logic                        push;     // Load word offered to the FIFO.
    logic [smio_pkg::FIFO_W-1:0] pdata;    // Load word: column and byte.
    logic                        fill;     // Buffer clear pulse.
    logic                        rst;      // Reset command pulse.
    logic                        ovr;      // Load word dropped, sticky.
    logic                        wp_hit;   // Protect pin low during a load.
  } smio_xfer_state_t;

  smio_xfer_state_t s;       // Registered state.
  smio_xfer_state_t next_s;  // Next state.
  logic             rise;    // Link clock rising edge inside a frame.
  logic             fall;    // Link clock falling edge inside a frame.
  logic [7:0]       word;    // Byte driven on this falling edge.

  smio_fifo_if #(.W(smio_pkg::FIFO_W)) fq ();

  // Load data buffer between the link and the cache write port.
  smio_fifo #(.W(smio_pkg::FIFO_W), .DEPTH(DEPTH)) u_fifo (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .f       (fq.store)
  );

  // FIFO filling and draining connections.
  assign fq.wr_valid = s.push;
  assign fq.wr_data  = s.pdata;
  assign fq.rd_ready = wr_ready;

  // Outputs come straight from registers.
  assign wr_valid                     = fq.rd_valid;
  assign wr_data                      = fq.rd_data[7:0];
  assign wr_col                       = fq.rd_data[smio_pkg::FIFO_W-1:8];
  assign data_lanes_zero_to_three_out = s.io_out;
  assign data_lanes_zero_to_three_oe  = s.io_oe;
  assign rd_req                       = s.rd_req;
  assign rd_col                       = s.rd_col;
  assign buf_fill                     = s.fill;
  assign soft_reset                   = s.rst;
  assign load_overrun                 = s.ovr;
  assign wp_low_load                  = s.wp_hit;

  // Edges are found on the synchronised clock, never on the first stage.
  assign rise = s.sck_s && !s.sck_d && !s.cs_s;
  assign fall = !s.sck_s && s.sck_d && !s.cs_s;

  // Sequencer: samples lanes on rising edges and drives them on falling edges.
  always_comb begin
    next_s        = s;
    word          = s.tx;
    next_s.sck_m  = sck;
    next_s.sck_s  = s.sck_m;
    next_s.sck_d  = s.sck_s;
    next_s.cs_m   = cs_n;
    next_s.cs_s   = s.cs_m;
    next_s.io_m   = data_lanes_zero_to_three_in;
    next_s.io_s   = s.io_m;
    next_s.wp_m   = wp_n;
    next_s.wp_s   = s.wp_m;
    next_s.rd_req = 1'b0;
    next_s.push   = 1'b0;
    next_s.fill   = 1'b0;
    next_s.rst    = 1'b0;
    // A reset command clears the drop flag, but a drop in the same cycle wins.
    if (s.rst) begin
      next_s.ovr = 1'b0;
    end
    if (s.push && !fq.wr_ready) begin
      next_s.ovr = 1'b1;
    end
    // Read data arrives from the cache buffer.
    if (rd_ack && s.pend) begin
      next_s.nxt    = rd_data;
      next_s.nxt_ok = 1'b1;
      next_s.pend   = 1'b0;
    end
    // Keeps one read byte fetched ahead of the shifter.
    if ((s.st == smio_pkg::ST_DUMMY || s.st == smio_pkg::ST_RDATA) && !s.nxt_ok && !s.pend) begin
      next_s.rd_req = 1'b1;
      next_s.rd_col = s.col;
      next_s.col    = smio_pkg::col_next(s.col);
      next_s.pend   = 1'b1;
    end
    if (s.cs_s) begin
      // Deselected: release the lanes and wait for the next opcode.
      next_s.st     = smio_pkg::ST_IDLE;
      next_s.cnt    = smio_pkg::CNT_ZERO;
      next_s.lanes  = smio_pkg::LANE1;
      next_s.io_oe  = smio_pkg::OE_NONE;
      next_s.nxt_ok = 1'b0;
    end else if (rise) begin
      next_s.sh  = smio_pkg::shift_in(s.sh, s.io_s, s.lanes);
      next_s.cnt = s.cnt + 5'h01;
      case (s.st)
        smio_pkg::ST_IDLE: begin
          if (s.cnt == smio_pkg::last_tick(smio_pkg::BYTE_BITS, smio_pkg::LANE1)) begin
            next_s.op  = next_s.sh[7:0];
            next_s.cnt = smio_pkg::CNT_ZERO;
            next_s.st  = smio_pkg::ST_ADDR;
            case (next_s.sh[7:0])
              smio_pkg::OP_RESET: begin
                next_s.rst = 1'b1;
                next_s.st  = smio_pkg::ST_SKIP;
              end
              smio_pkg::OP_LOAD, smio_pkg::OP_LOAD_QUAD: begin
                next_s.fill   = 1'b1;
                next_s.wp_hit = 1'b0;
              end
              smio_pkg::OP_LOAD_RND, smio_pkg::OP_LOAD_QUAD_RND: begin
                next_s.wp_hit = 1'b0;
              end
              smio_pkg::OP_FAST_DUAL: begin
                next_s.lanes = smio_pkg::LANE2;
              end
              smio_pkg::OP_FAST_QUAD: begin
                next_s.lanes = smio_pkg::LANE4;
              end
              smio_pkg::OP_RD_DUAL, smio_pkg::OP_RD_QUAD: begin
                next_s.lanes = smio_pkg::LANE1;
              end
              default: begin
                next_s.st = smio_pkg::ST_SKIP;
              end
            endcase
          end
        end
        smio_pkg::ST_ADDR: begin
          if (s.cnt == smio_pkg::last_tick(smio_pkg::ADDR_BITS, s.lanes)) begin
            next_s.col   = next_s.sh[smio_pkg::COL_W-1:0];
            next_s.cnt   = smio_pkg::CNT_ZERO;
            next_s.st    = smio_pkg::ST_DUMMY;
            next_s.lanes = smio_pkg::LANE4;
            case (s.op)
              smio_pkg::OP_RD_DUAL, smio_pkg::OP_FAST_DUAL: begin
                next_s.lanes = smio_pkg::LANE2;
              end
              smio_pkg::OP_RD_QUAD, smio_pkg::OP_FAST_QUAD: begin
                next_s.lanes = smio_pkg::LANE4;
              end
              smio_pkg::OP_LOAD_QUAD, smio_pkg::OP_LOAD_QUAD_RND: begin
                next_s.st = smio_pkg::ST_WDATA;
              end
              default: begin
                next_s.st    = smio_pkg::ST_WDATA;
                next_s.lanes = smio_pkg::LANE1;
              end
            endcase
          end
        end
        smio_pkg::ST_DUMMY: begin
          // Latency lane values are shifted in and never used.
          if (s.cnt == smio_pkg::DUMMY_LAST) begin
            next_s.cnt = smio_pkg::CNT_ZERO;
            next_s.st  = smio_pkg::ST_RDATA;
          end
        end
        smio_pkg::ST_WDATA: begin
          if (!s.wp_s) begin
            next_s.wp_hit = 1'b1;
          end
          if (s.cnt == smio_pkg::last_tick(smio_pkg::BYTE_BITS, s.lanes)) begin
            next_s.push  = 1'b1;
            next_s.pdata = {s.col, next_s.sh[7:0]};
            next_s.col   = smio_pkg::col_next(s.col);
            next_s.cnt   = smio_pkg::CNT_ZERO;
          end
        end
        default: begin
          // Read data clocks are counted on falling edges; skipped frames idle.
          next_s.cnt = s.cnt;
        end
      endcase
    end else if (fall) begin
      case (s.st)
        smio_pkg::ST_DUMMY: begin
          // Dual buffer read takes over its two lanes during latency.
          if (s.op == smio_pkg::OP_RD_DUAL) begin
            next_s.io_oe = smio_pkg::lane_mask(smio_pkg::LANE2);
          end
        end
        smio_pkg::ST_RDATA: begin
          if (s.cnt == smio_pkg::CNT_ZERO) begin
            word          = s.nxt;
            next_s.nxt_ok = 1'b0;
          end
          next_s.io_oe  = smio_pkg::lane_mask(s.lanes);
          next_s.io_out = (s.lanes == smio_pkg::LANE4) ? word[7:4] : {2'h0, word[7:6]};
          next_s.tx     = 8'(word << s.lanes);
          next_s.cnt    = (s.cnt == smio_pkg::last_tick(smio_pkg::BYTE_BITS, s.lanes)) ?
                          smio_pkg::CNT_ZERO : s.cnt + 5'h01;
        end
        default: begin
          next_s.io_oe = s.io_oe;
        end
      endcase
    end
    if (!resetn) begin
      next_s       = '0;
      next_s.st    = smio_pkg::ST_IDLE;
      next_s.lanes = smio_pkg::LANE1;
      next_s.cs_m  = 1'b1;
      next_s.cs_s  = 1'b1;
      next_s.wp_m  = 1'b1;
      next_s.wp_s  = 1'b1;
    end
  end

  // Registers the state.
  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end

  // Checks of the link behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // A falling edge in the latency phase.
  sequence dummy_fall_s;
    (s.st == smio_pkg::ST_DUMMY) && fall;
  endsequence
  // The rising edge that completes a load byte.
  sequence byte_done_s;
    (s.st == smio_pkg::ST_WDATA) && rise && (s.cnt == smio_pkg::last_tick(smio_pkg::BYTE_BITS, s.lanes));
  endsequence
  // A falling edge in the read data phase.
  sequence data_fall_s;
    (s.st == smio_pkg::ST_RDATA) && fall;
  endsequence

  dual_rd_lanes_a: assert property (data_fall_s ##0 (s.op == smio_pkg::OP_RD_DUAL) |=>
    (s.io_oe == smio_pkg::lane_mask(smio_pkg::LANE2)) && (s.io_out[3:2] == 2'h0))
    else $error("dual read does not drive exactly two lanes");
  dual_latency_a: assert property (dummy_fall_s ##0 (s.op == smio_pkg::OP_RD_DUAL) |=>
    s.io_oe == smio_pkg::lane_mask(smio_pkg::LANE2))
    else $error("dual read latency lanes not taken over");
  quad_rd_lanes_a: assert property (data_fall_s ##0 (s.lanes == smio_pkg::LANE4) |=>
    s.io_oe == smio_pkg::lane_mask(smio_pkg::LANE4))
    else $error("quad read does not drive four lanes");
  load_push_a: assert property (byte_done_s ##0 (s.lanes == smio_pkg::LANE1) |=> s.push ##1 !s.push)
    else $error("single-lane load byte not pushed once");
  quad_load_a: assert property (byte_done_s ##0 (s.lanes == smio_pkg::LANE4) |=>
    s.push && (s.pdata[7:0] == $past(next_s.sh[7:0])))
    else $error("quad load byte not captured");
  dummy_count_a: assert property ($rose(s.st == smio_pkg::ST_RDATA) |->
    ($past(s.cnt) == smio_pkg::DUMMY_LAST) && $past(rise))
    else $error("read data began before eight latency clocks");
  latency_quiet_a: assert property ((s.st == smio_pkg::ST_DUMMY) && (s.op != smio_pkg::OP_RD_DUAL) |->
    s.io_oe == smio_pkg::OE_NONE)
    else $error("lanes driven during fast read latency");
  wp_ignored_a: assert property ((s.st == smio_pkg::ST_DUMMY || s.st == smio_pkg::ST_RDATA) |=>
    $stable(s.wp_hit))
    else $error("protect pin acted during a read");
  col_capture_a: assert property ((s.st == smio_pkg::ST_ADDR) && rise &&
    (s.cnt == smio_pkg::last_tick(smio_pkg::ADDR_BITS, s.lanes)) |=> s.col == $past(next_s.sh[11:0]))
    else $error("column not taken from the address field");

endmodule : smio_xfer

// >>> verif/smio_host.sv
// Host model: drives chip select, link clock and lanes.
`timescale 1ns/1ps
module smio_host (
  // Clock.
  input  wire logic       ref_clk,
  // Device lane drive.
  input  wire logic [3:0] dev_out,
  input  wire logic [3:0] dev_oe,
  // Link pins.
  output logic            sck,
  output logic            cs_n,
  output logic [3:0]      lanes
);
  logic [3:0] host_oe;   // Lanes the host drives.
  logic [3:0] host_val;  // Host lane values.
  logic [3:0] float_pat; // Undriven lanes show this.

  // Idle bus: clock low, deselected.
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    host_oe = 4'h0;
    host_val = 4'h0;
    float_pat = 4'h5;
  end

  // Released lanes never keep a stale value.
  always @(posedge ref_clk) begin
    float_pat <= ~float_pat;
  end

  // Wire level from both parties' enables.
  assign lanes = (dev_oe & dev_out) | (~dev_oe & host_oe & host_val) | (~dev_oe & ~host_oe & float_pat);

  // One link clock; lanes set while low, sampled before the fall.
  task automatic clk1(input logic [3:0] oe, input logic [3:0] v, output logic [3:0] s);
    host_oe <= oe;
    host_val <= v;
    repeat (4) @(posedge ref_clk);
    sck <= 1'b1;
    repeat (4) @(posedge ref_clk);
    s = lanes;
    sck <= 1'b0;
  endtask : clk1

  // Sends a field on the given lanes, highest lane carrying the most significant bit.
  task automatic send(input int ln, input int nb, input logic [31:0] v);
    logic [3:0] m;
    logic [3:0] s;
    m = 4'((1 << ln) - 1);
    for (int k = 0; k < nb / ln; k++) begin
      clk1(m, 4'(v >> (nb - ln * (k + 1))) & m, s);
    end
  endtask : send

  // Selects the device.
  task automatic start();
    cs_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : start

  // Deselects and lets the lanes go.
  task automatic stop();
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'b1;
    host_oe <= 4'h0;
    repeat (12) @(posedge ref_clk);
  endtask : stop
endmodule : smio_host

// >>> verif/test_smio_xfer.sv
// Self-checking bench of the multi-lane transfer sequencer.
`timescale 1ns/1ps
module test_smio_xfer;
  localparam int POWER_ON_WAIT = 20; // Idle cycles before the first frame.
  logic        ref_clk, resetn, sck, cs_n, wp_n;          // Clock, reset and pins.
  logic [3:0]  lanes, dev_out, dev_oe;                    // Lane wire and device drive.
  logic        rd_req, rd_ack, wr_valid, wr_ready;        // Buffer handshakes.
  logic [11:0] rd_col, wr_col;                            // Buffer columns.
  logic [7:0]  rd_data, wr_data;                          // Buffer bytes.
  logic        buf_fill, soft_reset, load_overrun, wp_low_load; // Status.
  logic [19:0] exp_q[$];                                  // Expected column and byte.
  int          num_errors, total_checks, fill_cnt, reset_cnt, taken; // Counters.
  bit          chk_on, slow, hold_off;                    // Consumer modes.

  smio_xfer #(.DEPTH(smio_pkg::FIFO_DEPTH)) i_dut (.ref_clk(ref_clk), .resetn(resetn), .sck(sck),
    .cs_n(cs_n), .data_lanes_zero_to_three_in(lanes), .data_lanes_zero_to_three_out(dev_out),
    .data_lanes_zero_to_three_oe(dev_oe), .wp_n(wp_n), .rd_req(rd_req), .rd_col(rd_col),
    .rd_ack(rd_ack), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .wr_col(wr_col), .buf_fill(buf_fill), .soft_reset(soft_reset), .load_overrun(load_overrun),
    .wp_low_load(wp_low_load));
  smio_host i_host (.ref_clk(ref_clk), .dev_out(dev_out), .dev_oe(dev_oe), .sck(sck), .cs_n(cs_n),
    .lanes(lanes));

  // Clock.
  always #25 ref_clk = ~ref_clk;

  // Cache contents as a function of column.
  function automatic logic [7:0] cache_byte(input logic [11:0] c);
    return c[7:0] ^ {c[11:8], c[11:8]} ^ 8'h3c;
  endfunction : cache_byte

  // Counts a comparison and passes its outcome on.
  function automatic bit bad(input bit c);
    total_checks++;
    return c;
  endfunction : bad

  // Reports a mismatch.
  task automatic fail(input string m);
    num_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : fail

  // Prints counts and verdict.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // Cache answers one cycle late; consumer stalls on demand.
  always @(posedge ref_clk) begin
    rd_ack <= rd_req;
    rd_data <= rd_req ? cache_byte(rd_col) : ~cache_byte(rd_col);
    wr_ready <= hold_off ? 1'b0 : (slow ? ~wr_ready : 1'b1);
  end

  // Takes load words in order and counts pulses.
  always @(posedge ref_clk) begin
    if (resetn && wr_valid && wr_ready) begin
      taken++;
      if (chk_on && bad(exp_q.size() == 0 || {wr_col, wr_data} !== exp_q[0])) fail("load word wrong");
      if (chk_on && exp_q.size() != 0) void'(exp_q.pop_front());
    end
    if (buf_fill === 1'b1) fill_cnt++;
    if (soft_reset === 1'b1) reset_cnt++;
    if ((dev_oe & i_host.host_oe) != 4'h0) fail("lane driven by both ends");
  end

  // Waits, bounded, until every load word is taken.
  task automatic drain();
    int i;
    i = 0;
    while (i < 3000 && (exp_q.size() != 0 || wr_valid !== 1'b0)) begin
      @(posedge ref_clk);
      i++;
    end
    if (i == 3000) begin
      fail("load words not delivered");
      wrap_up();
    end
  endtask : drain

  // Read frame: address, latency, three bytes.
  task automatic read_frame(input logic [7:0] op, input int al, input int dl, input logic [11:0] col,
                            input logic [3:0] dummy_oe);
    logic [3:0] s;
    logic [7:0] b;
    i_host.start();
    i_host.send(1, 8, 32'(op));
    i_host.send(al, 16, {16'h0, 4'hb, col});
    for (int k = 0; k < smio_pkg::DUMMY_CLKS; k++) begin
      i_host.clk1(4'h0, 4'h0, s);
    end
    if (bad(dev_oe !== dummy_oe)) fail("lane enables wrong in latency");
    for (int i = 0; i < 3; i++) begin
      b = 8'h00;
      for (int c = 0; c < 8 / dl; c++) begin
        i_host.clk1(4'h0, 4'h0, s);
        b = 8'((b << dl) | (s & 4'((1 << dl) - 1)));
      end
      if (bad(b !== cache_byte(col + 12'(i)))) fail("read byte wrong");
    end
    i_host.stop();
  endtask : read_frame

  // Load frame of n bytes from col.
  task automatic load_frame(input logic [7:0] op, input int ln, input logic [11:0] col, input int n);
    logic [7:0] d;
    i_host.start();
    i_host.send(1, 8, 32'(op));
    i_host.send(1, 16, {16'h0, 4'h7, col});
    for (int i = 0; i < n; i++) begin
      d = 8'(col) ^ 8'(i * 37);
      exp_q.push_back({col + 12'(i), d});
      i_host.send(ln, 8, {24'h0, d});
    end
    i_host.stop();
  endtask : load_frame

  // Reset command as first frame.
  task automatic sc_first_reset();
    load_frame(smio_pkg::OP_RESET, 1, 12'h000, 0);
    exp_q.delete();
    if (bad(reset_cnt !== 1 || fill_cnt !== 0)) fail("reset pulse count wrong");
  endtask : sc_first_reset

  // Buffer reads with write-protect low, one wrapping the column.
  task automatic sc_buffer_reads();
    load_frame(8'h5a, 1, 12'h040, 2);
    exp_q.delete();
    if (bad(taken !== 0 || fill_cnt !== 0)) fail("unknown opcode acted");
    wp_n <= 1'b0;
    read_frame(smio_pkg::OP_RD_DUAL, 1, 2, 12'hffe, 4'h3);
    read_frame(smio_pkg::OP_RD_QUAD, 1, 4, 12'h123, 4'h0);
    if (bad(wp_low_load !== 1'b0)) fail("write-protect seen in read");
  endtask : sc_buffer_reads

  // Fast reads with multi-lane address.
  task automatic sc_fast_reads();
    read_frame(smio_pkg::OP_FAST_DUAL, 2, 2, 12'h7f0, 4'h0);
    read_frame(smio_pkg::OP_FAST_QUAD, 4, 4, 12'h055, 4'h0);
    if (bad(wp_low_load !== 1'b0)) fail("write-protect seen in fast read");
    wp_n <= 1'b1;
  endtask : sc_fast_reads

  // All four loads, consumer stalling, write-protect low in one.
  task automatic sc_loads();
    int f0;
    f0 = fill_cnt;
    chk_on = 1'b1;
    slow <= 1'b1;
    load_frame(smio_pkg::OP_LOAD, 1, 12'h010, 4);
    load_frame(smio_pkg::OP_LOAD_RND, 1, 12'hffc, 8);
    wp_n <= 1'b0;
    load_frame(smio_pkg::OP_LOAD_QUAD, 4, 12'h2a4, 6);
    wp_n <= 1'b1;
    if (bad(wp_low_load !== 1'b1)) fail("write-protect during load not flagged");
    load_frame(smio_pkg::OP_LOAD_QUAD_RND, 4, 12'h3f8, 4);
    drain();
    if (bad(wp_low_load !== 1'b0 || fill_cnt - f0 !== 2)) fail("load flags or clear pulses wrong");
  endtask : sc_loads

  // Fills the buffer past full, drains it, clears the flag by reset command.
  task automatic sc_overrun();
    int t0;
    chk_on = 1'b0;
    hold_off <= 1'b1;
    t0 = taken;
    load_frame(smio_pkg::OP_LOAD_QUAD, 4, 12'h100, 40);
    exp_q.delete();
    if (bad(load_overrun !== 1'b1)) fail("dropped bytes not flagged");
    hold_off <= 1'b0;
    drain();
    if (bad(taken - t0 < smio_pkg::FIFO_DEPTH || taken - t0 > 34)) fail("buffer depth wrong");
    load_frame(smio_pkg::OP_RESET, 1, 12'h000, 0);
    exp_q.delete();
    if (bad(load_overrun !== 1'b0 || reset_cnt !== 2)) fail("reset command did not clear flag");
  endtask : sc_overrun

  // Main sequence.
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    wp_n = 1'b1;
    rd_ack = 1'b0;
    rd_data = 8'h00;
    wr_ready = 1'b1;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (POWER_ON_WAIT) @(posedge ref_clk);
    sc_first_reset();
    sc_buffer_reads();
    sc_fast_reads();
    sc_loads();
    sc_overrun();
    wrap_up();
  end
endmodule : test_smio_xfer
